/* bench/ntp_ate_model.sv */
// Tester model: drives control and chain pins
`timescale 1ns/1ps
module ntp_ate_model (
  input wire logic clk_sys,
  input wire logic [1:0] step,
  input wire logic [2:0] n_low,
  output ntp_pkg::ntp_ctl_t ctl = '{1'b1, 1'b0, 1'b0},
  output logic [3:0] chain_in = '0
);
  import ntp_pkg::*;
  always @(posedge clk_sys) begin
    ctl <= step == 2'h1 ? '{1'b0, 1'b1, 1'b1} :
      step == 2'h2 ? '{1'b0, 1'b0, 1'b1} : '{1'b1, 1'b0, 1'b0};
    // Released pins wander rather than hold a stale level
    chain_in <= step == 2'h0 ? ~chain_in : 4'hf << n_low;
  end
endmodule : ntp_ate_model

/* bench/ntp_nand_tree_chk.sv */
// Port-level assertions for the pin-chain test block
`timescale 1ns/1ps
module ntp_nand_tree_chk #(
  parameter int CHAIN_LEN = ntp_pkg::CHAIN_LEN_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ntp_pkg::ntp_ctl_t ctl,
  input wire logic [CHAIN_LEN-1:0] chain_in,
  input wire ntp_pkg::ntp_pad_t pad
);
  import ntp_pkg::*;
  wire logic on = !ctl.test_mode_b && ctl.interrupt_request_3
    && ctl.interrupt_request_5;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // One more pin dropped low, in cell order
  sequence s_step;
    on ##1 (on && |$past(chain_in) && chain_in == $past(chain_in) << 1);
  endsequence
  property p_tog;
    s_step |=> pad.bus_hold_request_out != $past(pad.bus_hold_request_out);
  endproperty
  a_tog: assert property (p_tog) else $error("no toggle");
  property p_ent; on |=> pad.chain_active && !pad.buffers_en; endproperty
  a_ent: assert property (p_ent) else $error("no entry");
  property p_oe; on |=> pad.bus_hold_request_oe; endproperty
  a_oe: assert property (p_oe) else $error("pad not driven");
  property p_all; on && &chain_in |=>
    pad.bus_hold_request_out == !CHAIN_LEN[0]; endproperty
  a_all: assert property (p_all) else $error("bad parity");
  property p_ena; !ctl.interrupt_request_5 |=> !pad.chain_active; endproperty
  a_ena: assert property (p_ena) else $error("chain on");
  property p_buf; !ctl.test_mode_b && ctl.interrupt_request_3 |=>
    !pad.buffers_en; endproperty
  a_buf: assert property (p_buf) else $error("buffers on");
  property p_ext; !ctl.interrupt_request_3 |=>
    pad.buffers_en && !pad.chain_active; endproperty
  a_ext: assert property (p_ext) else $error("no exit");
  property p_hold; pad.reset_needed |=> pad.reset_needed; endproperty
  a_hold: assert property (p_hold) else $error("flag lost");
endmodule : ntp_nand_tree_chk
bind ntp_nand_tree ntp_nand_tree_chk #(.CHAIN_LEN(CHAIN_LEN))
  ntp_nand_tree_chk_i (.clk_sys(clk_sys), .rst_b(rst_b), .ctl(ctl),
  .chain_in(chain_in), .pad(pad));

/* bench/ntp_nand_tree_tb.sv */
// Self-checking bench for the pin-chain test block
`timescale 1ns/1ps
module ntp_nand_tree_tb;
  import ntp_pkg::*;
  logic clk_sys = 0, rst_b = 0, func = 1;
  logic [1:0] step = 0;
  logic [2:0] n_low = 0;
  ntp_ctl_t ctl;
  logic [3:0] chain_in;
  ntp_pad_t pad;
  int err_count = 0, checks = 0, cyc = 0;
  ntp_ate_model ntp_ate_model_i (.clk_sys(clk_sys), .step(step),
    .n_low(n_low), .ctl(ctl), .chain_in(chain_in));
  ntp_nand_tree #(.CHAIN_LEN(4)) ntp_nand_tree_i (.clk_sys(clk_sys),
    .rst_b(rst_b), .ctl(ctl), .chain_in(chain_in),
    .bus_hold_request_func(func), .pad(pad));
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc > 2000) begin
    err_count++;
    finish_test();
  end
  task chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask : chk
  task go(input logic [1:0] s, input logic [2:0] n);
    @(posedge clk_sys);
    step <= s;
    n_low <= n;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : go
  task finish_test();
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task t_entry();
    go(1, 0);
    chk(pad === 5'b11010, "entry");
  endtask : t_entry
  task t_walk();
    for (int i = 1; i < 5; i++) begin
      go(1, 3'(i));
      chk(pad.bus_hold_request_out === !i[0], "walk");
    end
  endtask : t_walk
  task t_interrupt_request_5();
    go(2, 0);
    chk(pad.chain_active === 0 && pad.buffers_en === 0, "interrupt_request_5");
  endtask : t_interrupt_request_5
  task t_exit();
    go(0, 0);
    chk(pad === 5'b11101, "exit");
  endtask : t_exit
  task t_reset();
    @(posedge clk_sys);
    rst_b <= 0;
    go(0, 0);
    chk(pad === 5'b00100, "reset");
    @(posedge clk_sys);
    rst_b <= 1;
    go(0, 0);
    chk(pad === 5'b11100, "release");
  endtask : t_reset
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1;
    t_entry();
    t_walk();
    t_interrupt_request_5();
    t_exit();
    t_reset();
    finish_test();
  end
endmodule : ntp_nand_tree_tb

/* verilog/ntp_nand_tree.sv */
// Pin-chain continuity test: NAND cascade over the input pins
//
// Overview of operation
// - Enter test setup only with test pin low and interrupt_request_3 high.
// - With interrupt_request_5 asserted in test setup, chain result appears on bus_hold_request_out.
// - Chain output stays disabled while interrupt_request_5 is low.
// - Asserting interrupt_request_3 in test setup disables all output buffers except bus_hold_request_out while the chain runs.
// - Pins go low one at a time from disk_light_out; output toggles each.
// - Chain follows fixed cell order, not ascending pin order.
// - Final chain element is the bus_hold_request_out pin itself.
// - interrupt_request_3 low leaves test mode and re-enables buffers.
`timescale 1ns/1ps

module ntp_nand_tree #(
  parameter int CHAIN_LEN = ntp_pkg::CHAIN_LEN_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire ntp_pkg::ntp_ctl_t ctl,
  // Bit 0 is disk_light_out, then upward in cell order, not pin order
  input wire logic [CHAIN_LEN-1:0] chain_in,
  input wire logic bus_hold_request_func,
  output ntp_pkg::ntp_pad_t pad
);
  import ntp_pkg::*;

  ntp_state_t state_r;
  ntp_state_t state_nxt;

  logic setup_hit;
  logic chain_hit;
  logic tree_val;

  // Cascade of two-input NAND cells; the first cell sees a constant high
  function automatic logic nand_chain(input logic [CHAIN_LEN-1:0] pins);
    logic acc;
    acc = 1'b1;
    for (int i = 0; i < CHAIN_LEN; i++) begin
      acc = ~(pins[i] & acc);
    end
    return acc;
  endfunction : nand_chain

  // Test pin low with the buffer-disable pin high
  function automatic logic setup_req(input ntp_ctl_t c);
    logic hit;
    hit = ~c.test_mode_b & c.interrupt_request_3;
    return hit;
  endfunction : setup_req

  // Chain runs only when its enable pin is high as well
  function automatic logic chain_req(input ntp_ctl_t c);
    logic hit;
    hit = setup_req(c) & c.interrupt_request_5;
    return hit;
  endfunction : chain_req

  // Shared next-mode step for every state that may enter the test
  function automatic ntp_mode_t test_step(
    input logic setup,
    input logic chain,
    input ntp_mode_t idle
  );
    ntp_mode_t nxt;
    if (chain) begin
      nxt = NTP_CHAIN;
    end else if (setup) begin
      nxt = NTP_BUF_OFF;
    end else begin
      nxt = idle;
    end
    return nxt;
  endfunction : test_step

  function automatic ntp_mode_t next_mode(
    input ntp_mode_t cur,
    input logic setup,
    input logic chain
  );
    ntp_mode_t nxt;
    nxt = cur;
    case (cur)
      NTP_NORMAL: begin
        nxt = test_step(setup, chain, NTP_NORMAL);
      end
      NTP_BUF_OFF: begin
        // Leaving test leaves internal state undefined, so demand reset
        nxt = test_step(setup, chain, NTP_EXITED);
      end
      NTP_CHAIN: begin
        nxt = test_step(setup, chain, NTP_EXITED);
      end
      NTP_EXITED: begin
        // rst_b clears this; re-entry for retest also leaves it and drops the flag
        nxt = test_step(setup, chain, NTP_EXITED);
      end
      default: begin
        nxt = NTP_NORMAL;
      end
    endcase
    return nxt;
  endfunction : next_mode

  // Outside the test the pad carries its functional value
  function automatic ntp_pad_t pad_idle(
    input logic func,
    input logic flag
  );
    ntp_pad_t p;
    p = PAD_RST;
    p.bus_hold_request_out = func;
    p.bus_hold_request_oe = 1'b1;
    p.buffers_en = 1'b1;
    p.chain_active = 1'b0;
    p.reset_needed = flag;
    return p;
  endfunction : pad_idle

  function automatic ntp_pad_t pad_for(
    input ntp_mode_t m,
    input logic tree,
    input logic func
  );
    ntp_pad_t p;
    p = PAD_RST;
    case (m)
      NTP_CHAIN: begin
        // The observation pad keeps driving even with other buffers off
        p.bus_hold_request_out = tree;
        p.bus_hold_request_oe = 1'b1;
        p.buffers_en = 1'b0;
        p.chain_active = 1'b1;
        p.reset_needed = 1'b0;
      end
      NTP_BUF_OFF: begin
        // Enable pin low: every buffer off, the chain pad as well
        p.bus_hold_request_out = 1'b0;
        p.bus_hold_request_oe = 1'b0;
        p.buffers_en = 1'b0;
        p.chain_active = 1'b0;
        p.reset_needed = 1'b0;
      end
      NTP_EXITED: begin
        p = pad_idle(func, 1'b1);
      end
      NTP_NORMAL: begin
        p = pad_idle(func, 1'b0);
      end
      default: begin
        p = PAD_RST;
      end
    endcase
    return p;
  endfunction : pad_for

  // One register stage on the otherwise combinational chain
  always_comb begin
    state_nxt = state_r;
    setup_hit = setup_req(ctl);
    chain_hit = chain_req(ctl);
    tree_val = nand_chain(chain_in);
    state_nxt.mode = next_mode(state_r.mode, setup_hit, chain_hit);
    state_nxt.pad = pad_for(state_nxt.mode, tree_val, bus_hold_request_func);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= STATE_RST;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign pad = state_r.pad;

endmodule : ntp_nand_tree

/* verilog/ntp_pkg.sv */
// Shared types and reset values for the pin-chain continuity test block
package ntp_pkg;

  localparam int CHAIN_LEN_DEF = 118;

  typedef enum logic [1:0] {
    NTP_NORMAL,
    NTP_BUF_OFF,
    NTP_CHAIN,
    NTP_EXITED
  } ntp_mode_t;

  // Test control pins as seen by the device
  typedef struct packed {
    logic test_mode_b;
    logic interrupt_request_5;
    logic interrupt_request_3;
  } ntp_ctl_t;

  // Everything the block drives toward its pads
  typedef struct packed {
    logic bus_hold_request_out;
    logic bus_hold_request_oe;
    logic buffers_en;
    logic chain_active;
    logic reset_needed;
  } ntp_pad_t;

  typedef struct packed {
    ntp_mode_t mode;
    ntp_pad_t pad;
  } ntp_state_t;

  localparam ntp_pad_t PAD_RST = '{
    bus_hold_request_out: 1'b0,
    bus_hold_request_oe: 1'b0,
    buffers_en: 1'b1,
    chain_active: 1'b0,
    reset_needed: 1'b0
  };

  localparam ntp_state_t STATE_RST = '{mode: NTP_NORMAL, pad: PAD_RST};

endpackage : ntp_pkg
